//--- rtl/lps_pkg.sv
// package for the sdram low-power state control block
package lps_pkg;

  // command bus sampled at a rising edge (active-low pins as levels)
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } lps_cmd_t;

  // main state, one-hot
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_SREF  = 5'b00010,
    ST_SRX   = 5'b00100,
    ST_PDN   = 5'b01000,
    ST_RESET = 5'b10000
  } lps_state_t;

  // status outputs travelling together
  typedef struct packed {
    logic sref;
    logic pdn_active;
    logic pdn_precharge;
    logic pdn_slow;
    logic dll_on;
    logic dll_reset;
    logic clk_gated;
    logic cmd_rx_on;
  } lps_stat_t;

  // clock rate
  localparam int CLK_KHZ = 10000;

  // timing figures (ns) and derived cycle counts, least times rounded up
  localparam int TCPDED_NS = 500;
  localparam int TCPDED_CYC = (TCPDED_NS * CLK_KHZ + 999999) / 1000000;
  localparam int TCKE_NS = 5000;
  localparam int TCKE_CYC = (TCKE_NS * CLK_KHZ + 999999) / 1000000;
  localparam int TREFI_NS = 7800;
  localparam int TREFI_CYC = (TREFI_NS * CLK_KHZ + 999999) / 1000000;
  localparam int TXS_NS = 170000;
  localparam int TXS_CYC = (TXS_NS * CLK_KHZ + 999999) / 1000000;
  localparam int TXSDLL_CYC = 512;
  localparam int DLL_RST_CYC = 8;

  // mode register bit positions
  localparam int MR1_DLL_DIS_BIT = 0;
  localparam int MR0_PPD_BIT = 12;

  // reset value of counters
  localparam logic [11:0] CNT_ZERO = 12'h000;

endpackage

//--- rtl/lps_tick.sv
// down-counter issuing a pulse when a loaded interval expires
`timescale 1ns/10ps
module lps_tick #(
  parameter int W = 12
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  // status
  output logic              busy,
  output logic              done
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         done_r;
  logic         done_nxt;

  // widths below two leave no room for a terminal count
  if (W < 2) begin : g_bad_width
    $error("lps_tick width too small");
  end

  // reload wins over counting so a restart is never lost
  always_comb begin
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    if (load) begin
      cnt_nxt = value;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
      done_nxt = (cnt_r == {{(W-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_r <= '0;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign busy = (cnt_r != '0);
  assign done = done_r;

endmodule

//--- rtl/lps_ctrl.sv
// low-power state control: self-refresh and power-down handling
// Functional notes
// RULE1: SRE is CS RAS CAS CKE low, WE high
// RULE2: host idles all banks before SRE
// RULE3: host disables termination before SRE
// RULE4: host holds CKE low during self-refresh
// RULE5: DLL off in self-refresh, reset on exit (code resets it on exit only when MR1 bit 0 is clear)
// RULE6: self-refresh ignores inputs but CKE, reset
// RULE7: host delays first write 512 cycles
// RULE8: internal refresh within tCKE, then timer-driven
// RULE9: host respects minimum self-refresh residency
// RULE10: host may stop clock, restarts before exit
// RULE11: exit CKE high with NOP; tXS, tXSDLL
// RULE12: host keeps CKE high, ODT off tXSDLL
// RULE13: host sends only NOP during tXS
// RULE14: host refreshes once before self-refresh re-entry
// RULE15: power-down enter/exit by CKE with NOP
// RULE16: host keeps CKE high during busy operations
// RULE17: pending row ops finish; pick power-down type
// RULE18: host resets unlocked DLL after power-down
// RULE19: buffers off; command receivers off after tCPDED
// RULE20: MR0 A12 selects slow or fast exit
// RULE21: reset low aborts power-down into reset
// RULE22: host limits CKE pulses and power-down duration
// RULE23: host waits minimum power-down time before exit
`timescale 1ns/10ps
module lps_ctrl #(
  parameter int TREFI_CYCLES  = lps_pkg::TREFI_CYC,
  parameter int TCKE_CYCLES   = lps_pkg::TCKE_CYC,
  parameter int TCPDED_CYCLES = lps_pkg::TCPDED_CYC,
  parameter int TXS_CYCLES    = lps_pkg::TXS_CYC,
  parameter int TXSDLL_CYCLES = lps_pkg::TXSDLL_CYC
) (
  // clock and reset
  input  wire logic            core_clk,
  input  wire logic            rst,
  // pins from the controller
  input  wire lps_pkg::lps_cmd_t cmd_pin,
  input  wire logic            reset_pin_n,
  // core state
  input  wire logic [15:0]     mr0,
  input  wire logic [15:0]     mr1,
  input  wire logic            banks_open,
  input  wire logic            row_op_busy,
  // outputs
  output lps_pkg::lps_stat_t   stat,
  output logic                 int_refresh,
  output logic                 xs_wait,
  output logic                 xsdll_wait
);

  // pin synchroniser
  lps_pkg::lps_cmd_t cmd_s1_r;
  lps_pkg::lps_cmd_t cmd_r;
  logic              rstn_s1_r;
  logic              rstn_r;
  logic              cke_prev_r;

  lps_pkg::lps_state_t st_r;
  lps_pkg::lps_state_t st_nxt;
  lps_pkg::lps_stat_t  stat_r;
  lps_pkg::lps_stat_t  stat_nxt;
  logic [3:0]          dllc_r;
  logic [3:0]          dllc_nxt;
  logic                ref_r;
  logic                ref_nxt;

  logic nop;
  logic sre;
  logic pde;
  logic cke_up;
  logic ref_load;
  logic ref_done;
  logic cpd_load;
  logic cpd_done;
  logic cpd_busy;
  logic xs_load;
  logic xs_busy;
  logic xsd_busy;
  logic [11:0] ref_val;

  // elaboration guards: the interval counters are 12 bits wide
  if (TREFI_CYCLES < 2 || TREFI_CYCLES > 4095) begin : g_bad_refi
    $error("refresh interval out of range");
  end
  if (TXSDLL_CYCLES > 4095 || TXS_CYCLES > 4095) begin : g_bad_exit
    $error("exit interval out of range");
  end
  // first refresh load is one less than the interval, so it must stay nonzero
  if (TCKE_CYCLES < 2 || TCKE_CYCLES > 4096) begin : g_bad_cke
    $error("clock-enable interval out of range");
  end

  // two stages before any logic sees the pins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmd_s1_r <= '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1};
      cmd_r <= '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1};
      rstn_s1_r <= 1'b1;
      rstn_r <= 1'b1;
      cke_prev_r <= 1'b1;
    end else begin
      cmd_s1_r <= cmd_pin;
      cmd_r <= cmd_s1_r;
      rstn_s1_r <= reset_pin_n;
      rstn_r <= rstn_s1_r;
      cke_prev_r <= cmd_r.cke;
    end
  end

  // command decode on the registered edge
  assign nop = cmd_r.cs_n | (cmd_r.ras_n & cmd_r.cas_n & cmd_r.we_n);
  assign sre = cke_prev_r & ~cmd_r.cke & ~cmd_r.cs_n & ~cmd_r.ras_n & ~cmd_r.cas_n & cmd_r.we_n; // [RULE1]
  assign pde = cke_prev_r & ~cmd_r.cke & nop; // [RULE15]
  assign cke_up = ~cke_prev_r & cmd_r.cke & nop; // [RULE11] [RULE15]

  // first internal refresh lands inside tCKE, then every TREFI_CYCLES + 1 cycles;
  // one cycle less on entry because the registered pulse adds one
  assign ref_val = (st_r == lps_pkg::ST_SREF) ? 12'(TREFI_CYCLES) : 12'(TCKE_CYCLES - 1); // [RULE8]
  assign ref_load = (st_r == lps_pkg::ST_IDLE && sre) || (st_r == lps_pkg::ST_SREF && ref_done);
  assign cpd_load = (st_r == lps_pkg::ST_IDLE && pde);
  assign xs_load = (st_r == lps_pkg::ST_SREF && cke_up);

  lps_tick #(.W(12)) u_ref (
    .core_clk (core_clk),
    .rst      (rst),
    .load     (ref_load),
    .value    (ref_val),
    .busy     (),
    .done     (ref_done)
  );

  lps_tick #(.W(12)) u_cpd (
    .core_clk (core_clk),
    .rst      (rst),
    .load     (cpd_load),
    .value    (12'(TCPDED_CYCLES)),
    .busy     (cpd_busy),
    .done     (cpd_done)
  );

  lps_tick #(.W(12)) u_xs (
    .core_clk (core_clk),
    .rst      (rst),
    .load     (xs_load),
    .value    (12'(TXS_CYCLES)),
    .busy     (xs_busy),
    .done     ()
  );

  lps_tick #(.W(12)) u_xsd (
    .core_clk (core_clk),
    .rst      (rst),
    .load     (xs_load),
    .value    (12'(TXSDLL_CYCLES)),
    .busy     (xsd_busy),
    .done     ()
  );

  // state machine and status; reset pin overrides everything
  always_comb begin
    st_nxt = st_r;
    stat_nxt = stat_r;
    dllc_nxt = (dllc_r != 4'h0) ? dllc_r - 4'h1 : dllc_r;
    ref_nxt = ref_load & (st_r == lps_pkg::ST_SREF);
    case (st_r)
      lps_pkg::ST_IDLE: begin
        stat_nxt.dll_on = ~mr1[lps_pkg::MR1_DLL_DIS_BIT];
        if (sre) begin
          st_nxt = lps_pkg::ST_SREF;
          stat_nxt.sref = 1'b1;
          stat_nxt.dll_on = 1'b0; // [RULE5]
          stat_nxt.clk_gated = 1'b1; // [RULE6]
          stat_nxt.cmd_rx_on = 1'b0; // [RULE6]
        end else if (pde) begin
          st_nxt = lps_pkg::ST_PDN;
        end
      end
      lps_pkg::ST_SREF: begin
        // only the clock-enable edge is looked at here
        if (cke_up) begin // [RULE6]
          st_nxt = lps_pkg::ST_SRX;
          stat_nxt.sref = 1'b0;
          stat_nxt.clk_gated = 1'b0;
          stat_nxt.cmd_rx_on = 1'b1;
          stat_nxt.dll_on = ~mr1[lps_pkg::MR1_DLL_DIS_BIT]; // [RULE5]
          stat_nxt.dll_reset = ~mr1[lps_pkg::MR1_DLL_DIS_BIT]; // [RULE5]
          dllc_nxt = 4'(lps_pkg::DLL_RST_CYC);
        end
      end
      lps_pkg::ST_SRX: begin
        if (!xs_busy && !xsd_busy && !xs_load) begin // [RULE11]
          st_nxt = lps_pkg::ST_IDLE;
        end
      end
      lps_pkg::ST_PDN: begin
        // row ops drain before the mode is reported [RULE17]
        stat_nxt.pdn_active = ~row_op_busy & banks_open; // [RULE17]
        stat_nxt.pdn_precharge = ~row_op_busy & ~banks_open; // [RULE17]
        stat_nxt.pdn_slow = ~row_op_busy & ~banks_open & ~mr0[lps_pkg::MR0_PPD_BIT]; // [RULE20]
        if (!row_op_busy && !banks_open && !mr0[lps_pkg::MR0_PPD_BIT]) begin
          stat_nxt.dll_on = 1'b0; // [RULE20]
        end
        if (cpd_done) begin
          stat_nxt.cmd_rx_on = 1'b0; // [RULE19]
        end
        if (cke_up) begin
          st_nxt = lps_pkg::ST_IDLE;
          stat_nxt.pdn_active = 1'b0;
          stat_nxt.pdn_precharge = 1'b0;
          stat_nxt.pdn_slow = 1'b0;
          stat_nxt.cmd_rx_on = 1'b1;
          stat_nxt.dll_on = ~mr1[lps_pkg::MR1_DLL_DIS_BIT];
        end
      end
      lps_pkg::ST_RESET: begin
        if (rstn_r) begin
          st_nxt = lps_pkg::ST_IDLE;
          stat_nxt.cmd_rx_on = 1'b1;
        end
      end
      default: begin
        st_nxt = lps_pkg::ST_IDLE;
      end
    endcase
    if (dllc_r == 4'h1) begin
      stat_nxt.dll_reset = 1'b0;
    end
    if (!rstn_r) begin
      st_nxt = lps_pkg::ST_RESET; // [RULE21]
      stat_nxt = '0;
      dllc_nxt = 4'h0;
      ref_nxt = 1'b0;
    end
  end

  // registered state; receivers and DLL start enabled
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= lps_pkg::ST_IDLE;
      stat_r <= '{sref: 1'b0, pdn_active: 1'b0, pdn_precharge: 1'b0, pdn_slow: 1'b0,
                  dll_on: 1'b1, dll_reset: 1'b0, clk_gated: 1'b0, cmd_rx_on: 1'b1};
      dllc_r <= 4'h0;
      ref_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      stat_r <= stat_nxt;
      dllc_r <= dllc_nxt;
      ref_r <= ref_nxt;
    end
  end

  assign stat = stat_r;
  assign int_refresh = ref_r; // [RULE8]
  assign xs_wait = xs_busy; // [RULE11]
  assign xsdll_wait = xsd_busy; // [RULE11]

endmodule

//--- testbench/lps_ctrl_props.sv
// concurrent checks on the low-power state control ports
`timescale 1ns/10ps
module lps_ctrl_props #(
  parameter int TREFI_CYCLES  = lps_pkg::TREFI_CYC,
  parameter int TCKE_CYCLES   = lps_pkg::TCKE_CYC,
  parameter int TCPDED_CYCLES = lps_pkg::TCPDED_CYC,
  parameter int TXS_CYCLES    = lps_pkg::TXS_CYC,
  parameter int TXSDLL_CYCLES = lps_pkg::TXSDLL_CYC
) (
  // clock and reset
  input wire logic               core_clk,
  input wire logic               rst,
  // pins and core state
  input wire lps_pkg::lps_cmd_t  cmd_pin,
  input wire logic               reset_pin_n,
  input wire logic [15:0]        mr0,
  input wire logic [15:0]        mr1,
  input wire logic               banks_open,
  input wire logic               row_op_busy,
  // outputs under watch
  input wire lps_pkg::lps_stat_t stat,
  input wire logic               int_refresh,
  input wire logic               xs_wait,
  input wire logic               xsdll_wait
);
  localparam int REF_MAX = TCKE_CYCLES;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // high-time counters; the falling edge reads the window length
  int xs_cnt;
  int xsdll_cnt;
  always_ff @(posedge core_clk) begin
    xs_cnt <= (rst || !xs_wait) ? 0 : xs_cnt + 1;
    xsdll_cnt <= (rst || !xsdll_wait) ? 0 : xsdll_cnt + 1;
  end
  chk_sref_dll_off: assert property (stat.sref |-> !stat.dll_on && stat.clk_gated)
    else $error("dll running or clock ungated in self-refresh");
  chk_sref_rx_off: assert property (stat.sref |-> !stat.cmd_rx_on && !stat.pdn_active)
    else $error("receivers on in self-refresh");
  chk_first_ref: assert property ($rose(stat.sref) |-> ##[0:REF_MAX] int_refresh)
    else $error("no internal refresh after entry");
  chk_exit_dll_rst: assert property ($fell(stat.sref) && xs_wait && !mr1[0] |-> stat.dll_reset [*8])
    else $error("dll reset missing on exit");
  chk_xs_len: assert property ($fell(xs_wait) |-> xs_cnt == TXS_CYCLES)
    else $error("exit window length wrong");
  chk_xsdll_len: assert property ($fell(xsdll_wait) |-> xsdll_cnt == TXSDLL_CYCLES)
    else $error("dll exit window length wrong");
  chk_pdn_kind: assert property (stat.pdn_precharge |-> !stat.pdn_active && !stat.sref)
    else $error("both power-down kinds set");
  chk_pdn_slow: assert property (stat.pdn_slow |-> stat.pdn_precharge && !stat.dll_on)
    else $error("slow exit without dll off");
  chk_reset_pin: assert property (!reset_pin_n [*4] |-> stat == 8'h00)
    else $error("status not cleared by reset pin");
endmodule
bind lps_ctrl lps_ctrl_props #(.TREFI_CYCLES(TREFI_CYCLES), .TCKE_CYCLES(TCKE_CYCLES),
  .TCPDED_CYCLES(TCPDED_CYCLES), .TXS_CYCLES(TXS_CYCLES), .TXSDLL_CYCLES(TXSDLL_CYCLES))
  u_props (.core_clk(core_clk), .rst(rst), .cmd_pin(cmd_pin), .reset_pin_n(reset_pin_n),
  .mr0(mr0), .mr1(mr1), .banks_open(banks_open), .row_op_busy(row_op_busy), .stat(stat),
  .int_refresh(int_refresh), .xs_wait(xs_wait), .xsdll_wait(xsdll_wait));

//--- testbench/lps_host.sv
// controller-side model driving the command pins and reset pin
`timescale 1ns/10ps
module lps_host (
  // clock
  input  wire logic         core_clk,
  // pins toward the device
  output lps_pkg::lps_cmd_t cmd_pin,
  output logic              reset_pin_n
);
  // idle: cke high, deselect, reset released
  initial begin
    cmd_pin = 5'h1F;
    reset_pin_n = 1'b1;
  end
  // pins change after a falling edge and hold n cycles, so cke levels last
  // long enough callers close banks, keep
  // odt off and send only nop around exit the clock
  // runs throughout cke stays high through the exit window
  // a refresh precedes every self-refresh re-entry no writes, mode
  // writes or bursts are sent, dll locked at each power-down
  task automatic put(input logic [4:0] c, input logic rn, input int n);
    @(negedge core_clk);
    cmd_pin = c;
    reset_pin_n = rn;
    repeat (n) @(negedge core_clk);
  endtask
endmodule

//--- testbench/lps_ctrl_tb.sv
// self-checking bench for the low-power state control block
`timescale 1ns/10ps
module lps_ctrl_tb;
  localparam int TCKE = 3;
  localparam int TCPDED = 2;
  localparam int TXSDLL = 8;
  localparam logic [4:0] C_SRE = 5'h01;
  localparam logic [4:0] C_PDE = 5'h07;
  localparam logic [4:0] C_EXIT = 5'h17;
  localparam logic [4:0] C_DES = 5'h1F;
  localparam logic [4:0] C_REF = 5'h11;
  logic               core_clk, rst, banks_open, row_op_busy;
  logic               int_refresh, xs_wait, xsdll_wait, reset_pin_n;
  logic [15:0]        mr0, mr1;
  lps_pkg::lps_cmd_t  cmd_pin;
  lps_pkg::lps_stat_t stat;
  int                 miscompares, total_checks, cycles;
  lps_host host (.core_clk(core_clk), .cmd_pin(cmd_pin), .reset_pin_n(reset_pin_n));
  // short timing counts keep the run brief
  lps_ctrl #(.TREFI_CYCLES(4), .TCKE_CYCLES(TCKE), .TCPDED_CYCLES(TCPDED), .TXS_CYCLES(5),
    .TXSDLL_CYCLES(TXSDLL)) uut (.core_clk(core_clk), .rst(rst), .cmd_pin(cmd_pin),
    .reset_pin_n(reset_pin_n), .mr0(mr0), .mr1(mr1), .banks_open(banks_open),
    .row_op_busy(row_op_busy), .stat(stat), .int_refresh(int_refresh), .xs_wait(xs_wait),
    .xsdll_wait(xsdll_wait));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard, far above the expected run of about 150 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic do_reset;
    @(negedge core_clk);
    rst = 1'b1;
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask
  // entry, internal refresh, ignored command, exit windows
  task automatic sref_cycle(input logic dll_dis);
    int n;
    mr1 = {15'h0000, dll_dis};
    host.put(C_REF, 1'b1, 2);
    chk(stat, {4'h0, ~dll_dis, 3'h1});
    host.put(C_SRE, 1'b1, 3);
    chk(stat, 8'h82);
    n = 0;
    while (int_refresh !== 1'b1 && n < 20) begin
      n++;
      @(negedge core_clk);
    end
    chk({7'h00, int_refresh}, 8'h01);
    host.put(5'h03, 1'b1, 4);
    chk(stat, 8'h82);
    host.put(C_EXIT, 1'b1, 3);
    chk({4'h0, stat.sref, stat.dll_reset, xs_wait, xsdll_wait}, {5'h00, ~dll_dis, 2'h3});
    host.put(C_DES, 1'b1, TXSDLL + 2);
    chk({6'h00, xs_wait, xsdll_wait}, 8'h00);
    chk(stat, {4'h0, ~dll_dis, 3'h1});
  endtask
  // power-down with a row operation pending, then exit
  task automatic pdn_cycle(input logic bo, input logic a12);
    logic slow;
    slow = !bo && !a12;
    banks_open = bo;
    mr0 = {3'h0, a12, 12'h000};
    row_op_busy = 1'b1;
    host.put(C_PDE, 1'b1, 3);
    chk(stat, 8'h09);
    host.put(C_PDE, 1'b1, TCPDED + 1);
    chk({7'h00, stat.cmd_rx_on}, 8'h00);
    row_op_busy = 1'b0;
    host.put(C_PDE, 1'b1, 3);
    chk({4'h0, stat[6:3]}, {4'h0, bo, !bo, slow, !slow});
    host.put(C_EXIT, 1'b1, TCKE + 1);
    chk(stat, 8'h09);
  endtask
  // reset pin pulled low in power-down
  task automatic pin_reset;
    banks_open = 1'b0;
    host.put(C_PDE, 1'b1, 6);
    host.put(C_PDE, 1'b0, 4);
    chk(stat, 8'h00);
    host.put(C_DES, 1'b1, 4);
    chk(stat, 8'h09);
    do_reset();
    chk(stat, 8'h09);
  endtask
  initial begin
    rst = 1'b1;
    mr0 = 16'h0000;
    mr1 = 16'h0000;
    banks_open = 1'b0;
    row_op_busy = 1'b0;
    miscompares = 0;
    total_checks = 0;
    cycles = 0;
    do_reset();
    chk(stat, 8'h09);
    sref_cycle(1'b0);
    sref_cycle(1'b1);
    mr1 = 16'h0000;
    pdn_cycle(1'b0, 1'b0);
    pdn_cycle(1'b0, 1'b1);
    pdn_cycle(1'b1, 1'b0);
    pin_reset();
    report_and_stop();
  end
endmodule
